// ---- design/srcc_top.v ----
// Relay scanner channel controller with Avalon-MM register slave
`timescale 1ns/1ps
`include "srcc_regs.vh"
// What this block does
// - Single close lights the closed channel indicator; 4-pole lights only the lower channel.
// - Single-close query reports the single-closed channel, omitting the paired upper one.
// - Single-close query never reports channels closed by multiple close.
// - Single close is refused while internal or external scan is enabled.
// - Open-all opens channels 1 to 10 and leaves channel 11 alone.
// - Open-all also sets scan operation selection to none.
// - Multiple close closes all listed channels together; channels 1 to 11 valid.
// - In multiple control, channel 11 closed means 2-pole, open means 4-pole.
// - Multiple close turns the front-panel channel indicator off.
// - Multiple-close query returns every closed channel, paired ones included.
// - Multiple open opens listed channels 1 to 11; opening 11 gives 4-pole.
// - Internal scan-list command stores the list and enables internal scan.
// - Internal list holds 2 to 10 channels numbered 1 to 10.
// - Internal list must be consecutive; a gapped list is invalid.
// - A list is given as separate channels or as a lower:upper range.
// - External list holds 2 to 800 channels numbered 1 to 800.
// - Defining the external list does not start scanning.
// - Selection accepts internal, external and none; none disables scanning.
// - List and selection queries return the last programmed values.
// - Single close opens closed channels 1 to 10 first, then closes the new one; channel 11 keeps its state.
// - In 4-pole single close, channel n pairs with n plus 5.
// - Single close pole mode follows the 2-wire or 4-wire measurement function.
module srcc_top (
  // Clock, reset, enable
  input  wire        CLK_SYS_IN,
  input  wire        RST_IN,
  input  wire        CE_IN,
  // Avalon-MM slave
  input  wire [4:0]  AVS_ADDRESS_IN,
  input  wire        AVS_READ_IN,
  input  wire        AVS_WRITE_IN,
  input  wire [31:0] AVS_WRITEDATA_IN,
  input  wire [3:0]  AVS_BYTEENABLE_IN,
  output reg  [31:0] AVS_READDATA_OUT,
  output wire        AVS_WAITREQUEST_OUT,
  // Measurement function
  input  wire        FOUR_WIRE_IN,
  // Relay card and scan control
  output reg  [10:0] RELAY_OUT,
  output reg  [3:0]  CHANNEL_FOUR_INDICATOR_OUT,
  output reg  [1:0]  SCAN_SEL_OUT,
  output reg         CMD_ERROR_OUT
);

  reg  [3:0]  single_chan;
  reg  [9:0]  int_list;
  reg  [9:0]  ext_lo;
  reg  [9:0]  ext_hi;
  reg         ack;

  wire        req = (AVS_READ_IN | AVS_WRITE_IN) & CE_IN;
  wire        wr_take = AVS_WRITE_IN & ack & CE_IN;
  wire        cmd_take = wr_take & (AVS_ADDRESS_IN == `SRCC_OFS_CMD) & (&AVS_BYTEENABLE_IN);
  wire        err_clr = wr_take & (AVS_ADDRESS_IN == `SRCC_OFS_STATUS) & AVS_BYTEENABLE_IN[0]
                        & AVS_WRITEDATA_IN[`SRCC_ST_ERROR];
  wire [3:0]  op = AVS_WRITEDATA_IN[`SRCC_OP_MSB:`SRCC_OP_LSB];
  wire [10:0] arg_mask = AVS_WRITEDATA_IN[`SRCC_ARG_MASK_MSB:0];
  wire [3:0]  arg_chan = AVS_WRITEDATA_IN[`SRCC_CHAN_MSB:0];
  wire [9:0]  arg_lo = AVS_WRITEDATA_IN[`SRCC_EXT_LO_MSB:0];
  wire [9:0]  arg_hi = AVS_WRITEDATA_IN[`SRCC_EXT_HI_MSB:`SRCC_EXT_HI_LSB];
  wire [1:0]  arg_sel = AVS_WRITEDATA_IN[1:0];

  // Answer one cycle after the request shows; master holds it meanwhile
  assign AVS_WAITREQUEST_OUT = (AVS_READ_IN | AVS_WRITE_IN) & ~ack;

  function [3:0] srcc_count;
    input [9:0] m;
    integer i;
    begin
      srcc_count = 4'h0;
      for (i = 0; i < 10; i = i + 1)
        srcc_count = srcc_count + {3'h0, m[i]};
    end
  endfunction

  // True when the set bits form one unbroken run
  function srcc_contig;
    input [9:0] m;
    reg   [10:0] filled;
    begin
      filled = {1'b0, m} | ({1'b0, m} - 11'h001);
      srcc_contig = ((filled + 11'h001) & {1'b0, m}) == 11'h000;
    end
  endfunction

  reg [10:0] next_relay;
  reg [3:0]  next_single;
  reg [3:0]  next_ind;
  reg [1:0]  next_sel;
  reg [9:0]  next_int;
  reg [9:0]  next_lo;
  reg [9:0]  next_hi;
  reg        bad;
  reg [3:0]  cnt;

  always @* begin
    next_relay  = RELAY_OUT;
    next_single = single_chan;
    next_ind    = CHANNEL_FOUR_INDICATOR_OUT;
    next_sel    = SCAN_SEL_OUT;
    next_int    = int_list;
    next_lo     = ext_lo;
    next_hi     = ext_hi;
    bad         = 1'b0;
    cnt         = srcc_count(arg_mask[9:0]);
    if (cmd_take) begin
      case (op)
        `SRCC_CMD_SINGLE: begin
          if (SCAN_SEL_OUT != `SRCC_SEL_NONE) begin
            bad = 1'b1;
          end else if (arg_chan == `SRCC_RST_CHAN ||
                       arg_chan > (FOUR_WIRE_IN ? `SRCC_MAX_CHAN_4P : `SRCC_MAX_CHAN_2P)) begin
            bad = 1'b1;
          end else begin
            // Channel 11 keeps its state; only input relays are swept
            next_relay[9:0] = 10'h000;
            next_relay[arg_chan - 4'h1] = 1'b1;
            if (FOUR_WIRE_IN)
              next_relay[arg_chan + `SRCC_PAIR_OFFSET - 4'h1] = 1'b1;
            next_single = arg_chan;
            next_ind    = arg_chan;
          end
        end
        `SRCC_CMD_OPEN_ALL: begin
          next_relay[9:0] = 10'h000;
          next_single = `SRCC_RST_CHAN;
          next_ind    = `SRCC_RST_CHAN;
          next_sel    = `SRCC_SEL_NONE;
        end
        `SRCC_CMD_MULTI_CLOSE: begin
          if (arg_mask == 11'h000) begin
            bad = 1'b1;
          end else begin
            next_relay = RELAY_OUT | arg_mask;
            next_ind   = `SRCC_RST_CHAN;
          end
        end
        `SRCC_CMD_MULTI_OPEN: begin
          if (arg_mask == 11'h000) begin
            bad = 1'b1;
          end else begin
            next_relay = RELAY_OUT & ~arg_mask;
            // Forget the single-closed channel once its relay is opened
            if (single_chan != `SRCC_RST_CHAN && arg_mask[single_chan - 4'h1]) begin
              next_single = `SRCC_RST_CHAN;
              next_ind    = `SRCC_RST_CHAN;
            end
          end
        end
        `SRCC_CMD_INT_LIST: begin
          if (arg_mask[10] || cnt < `SRCC_INT_MIN_COUNT || cnt > `SRCC_INT_MAX_COUNT) begin
            bad = 1'b1;
          end else if (!srcc_contig(arg_mask[9:0])) begin
            bad = 1'b1;
          end else begin
            next_int = arg_mask[9:0];
            next_sel = `SRCC_SEL_INT;
          end
        end
        `SRCC_CMD_EXT_LIST: begin
          if (arg_lo < `SRCC_EXT_MIN_CHAN || arg_hi > `SRCC_EXT_MAX_CHAN || arg_hi <= arg_lo) begin
            bad = 1'b1;
          end else begin
            next_lo = arg_lo;
            next_hi = arg_hi;
          end
        end
        `SRCC_CMD_SCAN_SEL: begin
          if (arg_sel == `SRCC_SEL_NONE || arg_sel == `SRCC_SEL_INT || arg_sel == `SRCC_SEL_EXT)
            next_sel = arg_sel;
          else
            bad = 1'b1;
        end
        default: begin
          bad = 1'b1;
        end
      endcase
    end
  end

  always @(posedge CLK_SYS_IN) begin
    if (RST_IN) begin
      ack                        <= 1'b0;
      AVS_READDATA_OUT           <= 32'h00000000;
      RELAY_OUT                  <= `SRCC_RST_RELAY;
      single_chan                <= `SRCC_RST_CHAN;
      CHANNEL_FOUR_INDICATOR_OUT <= `SRCC_RST_CHAN;
      SCAN_SEL_OUT               <= `SRCC_SEL_NONE;
      int_list                   <= `SRCC_RST_INT_LIST;
      ext_lo                     <= `SRCC_RST_EXT;
      ext_hi                     <= `SRCC_RST_EXT;
      CMD_ERROR_OUT              <= 1'b0;
    end else if (CE_IN) begin
      ack                        <= req & ~ack;
      RELAY_OUT                  <= next_relay;
      single_chan                <= next_single;
      CHANNEL_FOUR_INDICATOR_OUT <= next_ind;
      SCAN_SEL_OUT               <= next_sel;
      int_list                   <= next_int;
      ext_lo                     <= next_lo;
      ext_hi                     <= next_hi;
      // A new error wins over a clear in the same cycle
      if (bad)
        CMD_ERROR_OUT <= 1'b1;
      else if (err_clr)
        CMD_ERROR_OUT <= 1'b0;
      if (AVS_READ_IN & ~ack) begin
        case (AVS_ADDRESS_IN)
          `SRCC_OFS_STATUS:   AVS_READDATA_OUT <= {30'h0, ~RELAY_OUT[`SRCC_POLE_RELAY - 4'h1],
                                                   CMD_ERROR_OUT};
          `SRCC_OFS_RELAY:    AVS_READDATA_OUT <= {21'h0, RELAY_OUT};
          `SRCC_OFS_SINGLE:   AVS_READDATA_OUT <= {28'h0, single_chan};
          `SRCC_OFS_INT_LIST: AVS_READDATA_OUT <= {22'h0, int_list};
          `SRCC_OFS_EXT_LIST: AVS_READDATA_OUT <= {6'h0, ext_hi, 6'h0, ext_lo};
          `SRCC_OFS_SCAN_SEL: AVS_READDATA_OUT <= {30'h0, SCAN_SEL_OUT};
          default:            AVS_READDATA_OUT <= 32'h00000000;
        endcase
      end
    end
  end

endmodule

// ---- design/srcc_regs.vh ----
// Register offsets, command codes and field layout of the relay channel controller
`ifndef SRCC_REGS_VH
`define SRCC_REGS_VH

// Byte offsets (word aligned)
`define SRCC_OFS_CMD         5'h00
`define SRCC_OFS_STATUS      5'h04
`define SRCC_OFS_RELAY       5'h08
`define SRCC_OFS_SINGLE      5'h0c
`define SRCC_OFS_INT_LIST    5'h10
`define SRCC_OFS_EXT_LIST    5'h14
`define SRCC_OFS_SCAN_SEL    5'h18

// Command word fields
`define SRCC_OP_MSB          31
`define SRCC_OP_LSB          28
`define SRCC_ARG_MASK_MSB    10
`define SRCC_CHAN_MSB        3
`define SRCC_EXT_LO_MSB      9
`define SRCC_EXT_HI_MSB      25
`define SRCC_EXT_HI_LSB      16

// Command codes
`define SRCC_CMD_SINGLE      4'h1
`define SRCC_CMD_OPEN_ALL    4'h2
`define SRCC_CMD_MULTI_CLOSE 4'h3
`define SRCC_CMD_MULTI_OPEN  4'h4
`define SRCC_CMD_INT_LIST    4'h5
`define SRCC_CMD_EXT_LIST    4'h6
`define SRCC_CMD_SCAN_SEL    4'h7

// Scan operation selection values
`define SRCC_SEL_NONE        2'h0
`define SRCC_SEL_INT         2'h1
`define SRCC_SEL_EXT         2'h2

// Status bits
`define SRCC_ST_ERROR        0
`define SRCC_ST_FOUR_POLE    1

// Channel limits
`define SRCC_POLE_RELAY      4'hb
`define SRCC_PAIR_OFFSET     4'h5
`define SRCC_MAX_CHAN_2P     4'ha
`define SRCC_MAX_CHAN_4P     4'h5
`define SRCC_INT_MIN_COUNT   4'h2
`define SRCC_INT_MAX_COUNT   4'ha
`define SRCC_EXT_MIN_CHAN    10'h001
`define SRCC_EXT_MAX_CHAN    10'h320

// Reset values
`define SRCC_RST_RELAY       11'h000
`define SRCC_RST_CHAN        4'h0
`define SRCC_RST_INT_LIST    10'h000
`define SRCC_RST_EXT         10'h000

`endif

// ---- test/srcc_card.sv ----
// Relay card model: contacts follow the coil drive
`timescale 1ns/1ps
module srcc_card (
  input  wire        clk_in,
  input  wire [10:0] drive_in,
  output reg  [10:0] contact_out,
  output wire        four_pole_out
);
  // Contacts settle one clock after the coils
  always @(posedge clk_in) begin
    contact_out <= drive_in;
  end
  assign four_pole_out = ~contact_out[10];
endmodule

// ---- test/srcc_top_chk.sv ----
// Port checker for the relay channel controller
`timescale 1ns/1ps
module srcc_chk (
  input wire        CLK_SYS_IN,
  input wire        RST_IN,
  input wire        CE_IN,
  input wire [4:0]  AVS_ADDRESS_IN,
  input wire        AVS_READ_IN,
  input wire        AVS_WRITE_IN,
  input wire [31:0] AVS_WRITEDATA_IN,
  input wire        AVS_WAITREQUEST_OUT,
  input wire        FOUR_WIRE_IN,
  input wire [10:0] RELAY_OUT,
  input wire [3:0]  CHANNEL_FOUR_INDICATOR_OUT,
  input wire [1:0]  SCAN_SEL_OUT,
  input wire        CMD_ERROR_OUT
);
  default clocking dc @(posedge CLK_SYS_IN); endclocking
  // A frozen clock enable stretches the answer, so those cycles are not judged
  default disable iff (RST_IN || !CE_IN);
  wire        cmd = AVS_WRITE_IN && !AVS_WAITREQUEST_OUT && AVS_ADDRESS_IN == 5'h00;
  wire [3:0]  op  = AVS_WRITEDATA_IN[31:28];
  wire [3:0]  ch  = AVS_WRITEDATA_IN[3:0];
  wire [10:0] mk  = AVS_WRITEDATA_IN[10:0];
  sequence s_wait;
    AVS_WAITREQUEST_OUT ##1 !AVS_WAITREQUEST_OUT;
  endsequence
  sequence s_single;
    cmd && op == 4'h1 && SCAN_SEL_OUT == 2'h0 && ch != 4'h0;
  endsequence
  one_wait_a: assert property ($rose(AVS_READ_IN || AVS_WRITE_IN) |-> s_wait) else $error("late answer");
  two_pole_a: assert property (s_single ##0 (!FOUR_WIRE_IN && ch <= 4'ha) |=>
    RELAY_OUT[9:0] == 10'h1 << ($past(ch) - 4'h1) && CHANNEL_FOUR_INDICATOR_OUT == $past(ch))
    else $error("bad 2-pole close");
  pair_close_a: assert property (s_single ##0 (FOUR_WIRE_IN && ch <= 4'h5) |=>
    RELAY_OUT[9:0] == 10'h21 << ($past(ch) - 4'h1) && CHANNEL_FOUR_INDICATOR_OUT == $past(ch))
    else $error("bad pair close");
  scan_refuse_a: assert property (cmd && op == 4'h1 && SCAN_SEL_OUT != 2'h0 |=>
    $stable(RELAY_OUT) && CMD_ERROR_OUT) else $error("close during scan");
  open_all_a: assert property (cmd && op == 4'h2 |=>
    RELAY_OUT == {$past(RELAY_OUT[10]), 10'h000} && SCAN_SEL_OUT == 2'h0) else $error("bad open all");
  multi_close_a: assert property (cmd && op == 4'h3 && mk != 11'h0 |=>
    (RELAY_OUT & $past(mk)) == $past(mk) && CHANNEL_FOUR_INDICATOR_OUT == 4'h0) else $error("bad multi close");
  multi_open_a: assert property (cmd && op == 4'h4 && mk != 11'h0 |=>
    (RELAY_OUT & $past(mk)) == 11'h0) else $error("bad multi open");
  int_enable_a: assert property (cmd && op == 4'h5 |=>
    SCAN_SEL_OUT == 2'h1 || CMD_ERROR_OUT) else $error("internal scan off");
  ext_quiet_a: assert property (cmd && op == 4'h6 |=> $stable(SCAN_SEL_OUT)) else $error("scan moved");
  sel_set_a: assert property (cmd && op == 4'h7 && AVS_WRITEDATA_IN[1:0] != 2'h3 |=>
    SCAN_SEL_OUT == $past(AVS_WRITEDATA_IN[1:0])) else $error("bad selection");
endmodule
bind srcc_top srcc_chk u_chk (.CLK_SYS_IN, .RST_IN, .CE_IN, .AVS_ADDRESS_IN, .AVS_READ_IN, .AVS_WRITE_IN,
  .AVS_WRITEDATA_IN, .AVS_WAITREQUEST_OUT, .FOUR_WIRE_IN, .RELAY_OUT, .CHANNEL_FOUR_INDICATOR_OUT,
  .SCAN_SEL_OUT, .CMD_ERROR_OUT);

// ---- test/srcc_top_bench.sv ----
// Register-level bench of the relay channel controller
`timescale 1ns/1ps
module srcc_top_bench;
  reg         clk = 1'b0;
  reg         rst = 1'b1;
  reg  [4:0]  addr = 5'h00;
  reg         rd_en = 1'b0;
  reg         wr_en = 1'b0;
  reg  [31:0] wdata = 32'h0;
  reg         fw = 1'b0;
  reg         ce_en = 1'b1;
  wire [31:0] rdata;
  wire        wq;
  wire [10:0] relay;
  wire [10:0] contact;
  wire [3:0]  ind;
  wire [1:0]  sel;
  wire        err;
  wire        fpole;
  integer     mismatches = 0;
  integer     checked = 0;
  integer     i;
  always #10 clk = ~clk;
  srcc_top u_dut (.CLK_SYS_IN(clk), .RST_IN(rst), .CE_IN(ce_en), .AVS_ADDRESS_IN(addr), .AVS_READ_IN(rd_en),
    .AVS_WRITE_IN(wr_en), .AVS_WRITEDATA_IN(wdata), .AVS_BYTEENABLE_IN(4'hf), .AVS_READDATA_OUT(rdata),
    .AVS_WAITREQUEST_OUT(wq), .FOUR_WIRE_IN(fw), .RELAY_OUT(relay), .CHANNEL_FOUR_INDICATOR_OUT(ind),
    .SCAN_SEL_OUT(sel), .CMD_ERROR_OUT(err));
  srcc_card u_card (.clk_in(clk), .drive_in(relay), .contact_out(contact), .four_pole_out(fpole));
  task chk(input [31:0] got, input [31:0] exp);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        mismatches = mismatches + 1;
        $display("MISMATCH %0t got %h want %h", $time, got, exp);
      end
    end
  endtask
  // Holds the request until waitrequest is seen low, then idles a cycle
  task acc(input w, input [4:0] a, input [31:0] d, output [31:0] q);
    integer n;
    begin
      n = 0;
      addr <= a;
      wdata <= d;
      wr_en <= w;
      rd_en <= !w;
      @(posedge clk);
      while (wq !== 1'b0 && n < 20) begin
        n = n + 1;
        @(posedge clk);
      end
      if (n == 20) chk(32'h0, 32'h1);
      q = rdata;
      wr_en <= 1'b0;
      rd_en <= 1'b0;
      @(posedge clk);
    end
  endtask
  task wr(input [4:0] a, input [31:0] d);
    reg [31:0] q;
    begin
      acc(1'b1, a, d, q);
    end
  endtask
  task rd(input [4:0] a, input [31:0] exp);
    reg [31:0] q;
    begin
      acc(1'b0, a, 32'h0, q);
      chk(q, exp);
    end
  endtask
  // Error flag is sticky, so each refusal is cleared after it is seen
  task ce(input e);
    begin
      chk(err, e);
      wr(5'h04, 32'h1);
    end
  endtask
  task print_verdict;
    begin
      $display("mismatches %0d checked %0d", mismatches, checked);
      if (mismatches == 0 && checked > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(5'h08, 32'h0);
    rd(5'h04, 32'h2);
    wr(5'h00, 32'h1000_0003);
    chk(relay, 11'h004);
    rd(5'h0c, 32'h3);
    fw <= 1'b1;
    wr(5'h00, 32'h1000_0004);
    chk(relay, 11'h108);
    chk(ind, 4'h4);
    rd(5'h0c, 32'h4);
    wr(5'h00, 32'h1000_0006);
    chk(relay, 11'h108);
    ce(1'b1);
    wr(5'h00, 32'h3000_0401);
    chk(ind, 4'h0);
    rd(5'h08, 32'h509);
    rd(5'h0c, 32'h4);
    chk(fpole, 1'b0);
    wr(5'h00, 32'h4000_0408);
    rd(5'h04, 32'h2);
    chk(contact, 11'h101);
    wr(5'h00, 32'h7000_0002);
    wr(5'h00, 32'h1000_0001);
    chk(relay, 11'h101);
    ce(1'b1);
    wr(5'h00, 32'h3000_0400);
    wr(5'h00, 32'h2000_0000);
    chk(relay, 11'h400);
    chk(sel, 2'h0);
    wr(5'h00, 32'h5000_000e);
    rd(5'h10, 32'he);
    chk(sel, 2'h1);
    wr(5'h00, 32'h5000_000b);
    ce(1'b1);
    wr(5'h00, 32'h5000_0010);
    ce(1'b1);
    rd(5'h10, 32'he);
    wr(5'h00, 32'h6320_0001);
    chk(sel, 2'h1);
    rd(5'h14, 32'h0320_0001);
    wr(5'h00, 32'h6321_0001);
    ce(1'b1);
    for (i = 0; i < 4; i = i + 1) begin
      wr(5'h00, 32'h7000_0000 + i);
      rd(5'h18, (i < 3) ? i : 2);
    end
    ce(1'b1);
    // Open-all issued while the clock enable is low must wait for it
    ce_en <= 1'b0;
    fork
      wr(5'h00, 32'h2000_0000);
      begin
        repeat (4) @(posedge clk);
        chk(wq, 1'b1);
        chk(sel, 2'h2);
        ce_en <= 1'b1;
      end
    join
    chk(sel, 2'h0);
    chk(relay, 11'h400);
    rd(5'h1c, 32'h0);
    print_verdict;
  end
  initial begin
    #200000;
    mismatches = mismatches + 1;
    print_verdict;
  end
endmodule
